// File: hw/sweep_trigger_regs.vh
// Register map, field positions, reset values and encodings of the sweep
// trigger sequencer. Assumes inclusion by bare name from files under hw/ and test/.
`ifndef SWEEP_TRIGGER_REGS_VH
`define SWEEP_TRIGGER_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define REG_CTRL_OFF      12'h000
`define REG_MODE_OFF      12'h004
`define REG_OPEN_OFF      12'h008
`define REG_CMD_OFF       12'h00C
`define REG_STATUS_OFF    12'h010
`define REG_NPTS_OFF      12'h014

// ****************************************
// CTRL fields
// ****************************************
`define CTRL_SRC_LSB      0
`define CTRL_SRC_MSB      1
`define CTRL_POINT_BIT    2
`define CTRL_POS_EDGE_BIT 3
`define CTRL_RESET_VAL    32'h0000_0000

// Trigger source encodings
`define SRC_INTERNAL      2'h0
`define SRC_EXTERNAL      2'h1
`define SRC_BUS           2'h2

// Per-channel mode encodings, two bits per channel
`define MODE_CONT         2'h0
`define MODE_SINGLE       2'h1
`define MODE_HOLD         2'h2

// CMD bits (write one to act)
`define CMD_BUS_TRIG_BIT  0
`define CMD_ARM_BIT       1

// STATUS fields
`define STAT_BUSY_BIT     0
`define STAT_CHAN_LSB     4
`define STAT_POINT_LSB    16

`define NPTS_RESET_VAL    16'h0010

`endif

// File: hw/edge_trigger_detect.v
// External trigger synchroniser and edge detector.
// Assumes trig_pin is asynchronous to ref_clk.
`default_nettype none

module edge_trigger_detect
(
  // Clock and reset
  input  wire ref_clk,
  input  wire rst,
  // Pin and selection
  input  wire trig_pin,
  input  wire pos_edge,
  // Detected edge
  output reg  edge_pulse
);

  reg sync1_r;
  reg sync2_r;
  reg sync3_r;
  reg level_r;

  // ****************************************
  // Three stages; a change counts once stages two and three agree
  // ****************************************
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1_r    <= 1'b1;
      sync2_r    <= 1'b1;
      sync3_r    <= 1'b1;
      level_r    <= 1'b1;
      edge_pulse <= 1'b0;
    end
    else
    begin
      sync1_r    <= trig_pin;
      sync2_r    <= sync1_r;
      sync3_r    <= sync2_r;
      edge_pulse <= 1'b0;
      if ((sync2_r == sync3_r) && (sync3_r != level_r))
      begin
        level_r    <= sync3_r;
        edge_pulse <= (sync3_r == pos_edge);
      end
    end
  end

endmodule // edge_trigger_detect

`default_nettype wire

// File: hw/point_sweeper.v
// Walks the frequency points of one channel on request.
// Assumes the engine answers each point with a one-cycle done pulse.
`default_nettype none

module point_sweeper
#(
  parameter PW = 16
)
(
  // Clock and reset
  input  wire          ref_clk,
  input  wire          rst,
  // Control
  input  wire          start,
  input  wire [PW-1:0] num_points,
  // Engine handshake
  input  wire          point_done,
  output reg           point_start,
  // Position
  output reg  [PW-1:0] point_idx,
  output wire          last_point
);

  // Greater-or-equal, so a point count shrunk mid-sweep cannot run the index to wrap-around
  assign last_point = (point_idx >= num_points - {{(PW-1){1'b0}}, 1'b1});

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      point_start <= 1'b0;
      point_idx   <= {PW{1'b0}};
    end
    else
    begin
      point_start <= start;
      if (point_done)
      begin
        if (last_point)
          point_idx <= {PW{1'b0}};
        else
          point_idx <= point_idx + {{(PW-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // point_sweeper

`default_nettype wire

// File: hw/sweep_trigger_control.v
// Trigger sequencer: decides when a measurement cycle or point starts.
// Assumes an APB master on ref_clk and a measurement engine that pulses
// meas_point_done once per point it was asked to measure.
`include "sweep_trigger_regs.vh"
`default_nettype none

module sweep_trigger_control
#(
  parameter NCH = 4,
  parameter PW  = 16
)
(
  // Clock and reset
  input  wire                   ref_clk,
  input  wire                   rst,
  // APB slave
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [11:0]            paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  // External trigger
  input  wire                   external_trigger_input,
  // Measurement engine
  input  wire                   meas_point_done,
  output reg                    meas_point_start,
  output reg  [7:0]             meas_channel,
  output reg  [PW-1:0]          meas_point,
  output reg                    meas_busy
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam ST_IDLE  = 3'b001;
  localparam ST_START = 3'b010;
  localparam ST_WAIT  = 3'b100;

  reg  [2:0]       state_r;
  reg  [1:0]       src_r;
  reg              point_mode_r;
  reg              pos_edge_r;
  reg  [2*NCH-1:0] mode_r;
  reg  [NCH-1:0]   open_r;
  reg  [NCH-1:0]   armed_r;
  reg  [NCH-1:0]   in_cycle_r;
  reg  [PW-1:0]    npts_r;
  reg  [7:0]       chan_r;
  reg              bus_trig_r;
  reg              int_trig_r;
  reg              point_cycle_r;
  wire [NCH-1:0]   eligible;
  reg  [7:0]       first_ch;
  reg  [7:0]       next_ch;
  reg              have_next;
  reg  [31:0]      rd_nxt;
  reg              hit;
  wire             ext_edge;
  wire             pt_start;
  wire [PW-1:0]    pt_idx;
  wire             pt_last;
  wire             trig;
  wire             wr_en;
  wire             setup;
  integer          i;
  integer          j;

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;

  edge_trigger_detect u_edge
  (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .trig_pin   (external_trigger_input),
    .pos_edge   (pos_edge_r),
    .edge_pulse (ext_edge)
  );

  point_sweeper #(.PW(PW)) u_pts
  (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .start       (state_r == ST_START),
    .num_points  (npts_r),
    .point_done  (meas_point_done),
    .point_start (pt_start),
    .point_idx   (pt_idx),
    .last_point  (pt_last)
  );

  // ****************************************
  // Trigger selection
  // ****************************************
  assign trig = (src_r == `SRC_EXTERNAL) ? ext_edge :
                (src_r == `SRC_BUS)      ? bus_trig_r :
                int_trig_r;

  // Channels that may take part: open, and continuous or armed single
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : g_elig
      assign eligible[g] = open_r[g] &&
                           ((mode_r[2*g+1:2*g] == `MODE_CONT) ||
                            ((mode_r[2*g+1:2*g] == `MODE_SINGLE) && armed_r[g]));
    end
  endgenerate

  // Lowest eligible channel and next in-cycle channel after the current one
  always @*
  begin
    first_ch  = 8'h00;
    next_ch   = 8'h00;
    have_next = 1'b0;
    for (j = NCH - 1; j >= 0; j = j - 1)
    begin
      if (eligible[j])
        first_ch = j[7:0];
      if (in_cycle_r[j] && (j[7:0] > chan_r))
      begin
        next_ch   = j[7:0];
        have_next = 1'b1;
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_r          <= ST_IDLE;
      chan_r           <= 8'h00;
      in_cycle_r       <= {NCH{1'b0}};
      point_cycle_r    <= 1'b0;
      int_trig_r       <= 1'b0;
      meas_point_start <= 1'b0;
      meas_channel     <= 8'h00;
      meas_point       <= {PW{1'b0}};
      meas_busy        <= 1'b0;
    end
    else
    begin
      int_trig_r       <= (state_r == ST_IDLE) && (|eligible) && !int_trig_r;
      meas_point_start <= pt_start;
      meas_channel     <= chan_r;
      meas_point       <= pt_idx;
      meas_busy        <= (state_r != ST_IDLE);
      case (state_r)
        ST_IDLE:
        begin
          // Triggers while busy never reach here, so they are dropped
          if (trig && (|eligible))
          begin
            // Point stepping holds the channel set of the cycle in progress
            if (!(point_cycle_r && (|in_cycle_r)))
            begin
              in_cycle_r <= eligible;
              chan_r     <= first_ch;
            end
            point_cycle_r <= point_mode_r && (src_r == `SRC_EXTERNAL);
            state_r       <= ST_START;
          end
        end
        ST_START:
          state_r <= ST_WAIT;
        ST_WAIT:
        begin
          if (meas_point_done)
          begin
            if (!pt_last)
              state_r <= point_cycle_r ? ST_IDLE : ST_START;
            else if (have_next)
            begin
              chan_r  <= next_ch;
              state_r <= point_cycle_r ? ST_IDLE : ST_START;
            end
            else
            begin
              in_cycle_r <= {NCH{1'b0}};
              state_r    <= ST_IDLE;
            end
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      src_r        <= `SRC_INTERNAL;
      point_mode_r <= 1'b0;
      pos_edge_r   <= 1'b0;
      mode_r       <= {2*NCH{1'b0}};
      open_r       <= {NCH{1'b1}};
      armed_r      <= {NCH{1'b0}};
      npts_r       <= `NPTS_RESET_VAL;
      bus_trig_r   <= 1'b0;
    end
    else
    begin
      bus_trig_r <= wr_en && (paddr == `REG_CMD_OFF) && pwdata[`CMD_BUS_TRIG_BIT];
      if (wr_en && (paddr == `REG_CTRL_OFF))
      begin
        src_r        <= pwdata[`CTRL_SRC_MSB:`CTRL_SRC_LSB];
        point_mode_r <= pwdata[`CTRL_POINT_BIT];
        pos_edge_r   <= pwdata[`CTRL_POS_EDGE_BIT];
      end
      if (wr_en && (paddr == `REG_OPEN_OFF))
        open_r <= pwdata[NCH-1:0];
      if (wr_en && (paddr == `REG_NPTS_OFF) && (pwdata[PW-1:0] != {PW{1'b0}}))
        npts_r <= pwdata[PW-1:0];
      for (i = 0; i < NCH; i = i + 1)
      begin
        // Single finishing: the cycle's last point flips each single channel of the cycle to hold
        if ((state_r == ST_WAIT) && meas_point_done && pt_last && !have_next &&
            in_cycle_r[i] && (mode_r[2*i+:2] == `MODE_SINGLE))
        begin
          mode_r[2*i+:2] <= `MODE_HOLD;
          armed_r[i]     <= 1'b0;
        end
        else if (wr_en && (paddr == `REG_MODE_OFF))
        begin
          mode_r[2*i+:2] <= pwdata[2*i+:2];
          armed_r[i]     <= (pwdata[2*i+:2] == `MODE_SINGLE);
        end
        else if (wr_en && (paddr == `REG_CMD_OFF) && pwdata[`CMD_ARM_BIT] &&
                 (mode_r[2*i+:2] == `MODE_SINGLE))
          armed_r[i] <= 1'b1;
      end
    end
  end

  // ****************************************
  // APB read and answer
  // ****************************************
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    hit    = 1'b1;
    case (paddr)
      `REG_CTRL_OFF:
      begin
        rd_nxt[`CTRL_SRC_MSB:`CTRL_SRC_LSB] = src_r;
        rd_nxt[`CTRL_POINT_BIT]             = point_mode_r;
        rd_nxt[`CTRL_POS_EDGE_BIT]          = pos_edge_r;
      end
      `REG_MODE_OFF:   rd_nxt[2*NCH-1:0] = mode_r;
      `REG_OPEN_OFF:   rd_nxt[NCH-1:0]   = open_r;
      `REG_CMD_OFF:    rd_nxt[NCH-1:0]   = armed_r;
      `REG_STATUS_OFF:
      begin
        rd_nxt[`STAT_BUSY_BIT]             = (state_r != ST_IDLE);
        rd_nxt[`STAT_CHAN_LSB+7:`STAT_CHAN_LSB] = chan_r;
        rd_nxt[`STAT_POINT_LSB+PW-1:`STAT_POINT_LSB] = pt_idx;
      end
      `REG_NPTS_OFF:   rd_nxt[PW-1:0]    = npts_r;
      default:         hit               = 1'b0;
    endcase
  end

  // No wait state: answer in the first access cycle
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      if (setup && !pwrite)
        prdata <= rd_nxt;
    end
  end

endmodule // sweep_trigger_control

`default_nettype wire

// File: test/sweep_trigger_props.sv
// Port checker for the sweep trigger sequencer.
// Assumes it is bound to every sweep_trigger_control instance.
`default_nettype none
module sweep_trigger_props
#(
  parameter NCH = 4,
  parameter PW  = 16
)
(
  // Watched ports
  input wire logic          ref_clk,
  input wire logic          rst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          meas_point_done,
  input wire logic          meas_point_start,
  input wire logic [7:0]    meas_channel,
  input wire logic [PW-1:0] meas_point,
  input wire logic          meas_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Point bookkeeping
  // ****
  logic          open_r;
  logic [7:0]    ch_r;
  logic [PW-1:0] pt_r;
  always_ff @(posedge ref_clk)
  begin
    if (rst || meas_point_done)
      open_r <= 1'b0;
    else if (meas_point_start)
      open_r <= 1'b1;
    if (meas_point_start)
    begin
      ch_r <= meas_channel;
      pt_r <= meas_point;
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_start_pulse: assert property (meas_point_start |=> !meas_point_start)
    else $error("start longer than one cycle");
  a_start_busy: assert property (meas_point_start |-> meas_busy)
    else $error("start while not busy");
  a_one_point: assert property (meas_point_start |-> !open_r)
    else $error("start before previous point done");
  a_chan_range: assert property (meas_point_start |-> meas_channel < NCH)
    else $error("channel out of range");
  a_point_next: assert property (meas_point_start && meas_point != 0 |->
    meas_point == pt_r + 1'b1 && meas_channel == ch_r)
    else $error("point did not advance by one");
  a_busy_start: assert property ($rose(meas_busy) |-> ##[0:4] meas_point_start)
    else $error("busy without a start");
  cover property (meas_point_start && meas_point != 0);
  cover property (pslverr);
  cover property ($fell(meas_busy));
endmodule // sweep_trigger_props
bind sweep_trigger_control sweep_trigger_props #(.NCH(NCH), .PW(PW)) i_sweep_trigger_props (.ref_clk, .rst,
  .psel, .penable, .pready, .pslverr, .meas_point_done, .meas_point_start, .meas_channel, .meas_point, .meas_busy);
`default_nettype wire

// File: test/meas_engine_model.sv
// Behavioural measurement engine: answers each point request with a done pulse.
// Assumes start pulses for one cycle; lag delays the one-cycle answer.
`default_nettype none
module meas_engine_model
(
  // Clock
  input  wire logic       ref_clk,
  // Request and answer
  input  wire logic       start,
  input  wire logic [1:0] lag,
  output var  logic       done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Answer timer
  // ****
  logic [2:0] cnt_r = 3'h0;
  initial done = 1'b0;
  always @(posedge ref_clk)
  begin
    done <= 1'b0;
    if (start)
      cnt_r <= {1'b0, lag} + 3'h1;
    else if (cnt_r != 3'h0)
    begin
      cnt_r <= cnt_r - 3'h1;
      done <= (cnt_r == 3'h1);
    end
  end
endmodule // meas_engine_model
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the sweep trigger sequencer.
// Assumes the design under hw/ and the engine model beside this file.
`include "sweep_trigger_regs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        pin     = 1'b1;
  logic [1:0]  lag     = 2'h0;
  logic [31:0] seed    = 32'h0000_444f;
  logic        pready, pslverr, done, start, busy, err;
  logic [31:0] prdata, rd;
  logic [7:0]  ch;
  logic [15:0] pt, npts;
  logic [3:0]  mask;
  logic [23:0] obs[$], exq[$];
  int          fail_count = 0;
  int          tests_run  = 0;
  int          cyc        = 0;
  sweep_trigger_control #(.NCH(4), .PW(16)) i_sweep_trigger_control (.ref_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .external_trigger_input(pin), .meas_point_done(done),
    .meas_point_start(start), .meas_channel(ch), .meas_point(pt), .meas_busy(busy));
  meas_engine_model i_meas_engine_model (.ref_clk, .start, .lag, .done);
  initial forever #12.5 ref_clk = ~ref_clk;
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Kind 0 is a bus command, 1 a falling pin edge, 2 a rising one
  task automatic fire(int k);
    if (k == 0)
      apb(1'b1, `REG_CMD_OFF, 32'h0000_0001);
    else
    begin
      pin <= (k == 1);
      repeat (8) @(posedge ref_clk);
      pin <= (k != 1);
      repeat (8) @(posedge ref_clk);
    end
  endtask
  // Waits long enough for a trigger to be taken before trusting idle
  task automatic settle();
    repeat (20) @(posedge ref_clk);
    while (busy !== 1'b0) @(posedge ref_clk);
  endtask
  task automatic plan(logic [7:0] modes);
    for (int c = 0; c < 4; c++)
      if (mask[c] && modes[2*c+:2] != `MODE_HOLD)
        for (int p = 0; p < npts; p++)
          exq.push_back({8'(c), 16'(p)});
  endtask
  task automatic judge();
    cmp("points", exq.size(), obs.size());
    foreach (exq[i])
      if (i < obs.size())
        cmp("point", exq[i], obs[i]);
    exq.delete();
    obs.delete();
  endtask
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    lag <= 2'(cyc >> 1);
    if (start === 1'b1)
      obs.push_back({ch, pt});
    if (cyc == 30000)
    begin
      fail_count++;
      finish_test();
    end
  end
  // ****
  // Scenarios
  // ****
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, `REG_NPTS_OFF, 32'h0000_0000);
    cmp("npts reset", {16'h0000, `NPTS_RESET_VAL}, rd);
    apb(1'b1, `REG_NPTS_OFF, 32'h0000_0001);
    apb(1'b1, `REG_OPEN_OFF, 32'h0000_0001);
    repeat (1500) @(posedge ref_clk);
    cmp("retrigger", 1, obs.size() > 70);
    apb(1'b1, `REG_CTRL_OFF, {30'h0, `SRC_BUS});
    settle();
    rd = xs();
    mask = rd[3:0] | 4'h1;
    npts = {14'h0000, rd[5:4]} + 16'h0001;
    apb(1'b1, `REG_NPTS_OFF, {16'h0000, npts});
    apb(1'b1, `REG_OPEN_OFF, {28'h000_0000, mask});
    obs.delete();
    repeat (2)
    begin
      plan(8'h00);
      fire(0);
      fire(0);
      settle();
      judge();
    end
    fire(1);
    settle();
    judge();
    apb(1'b1, `REG_MODE_OFF, 32'h0000_00A9);
    apb(1'b0, `REG_CMD_OFF, 32'h0000_0000);
    cmp("armed", 32'h0000_0001, rd);
    plan(8'hA9);
    fire(0);
    settle();
    judge();
    apb(1'b0, `REG_MODE_OFF, 32'h0000_0000);
    cmp("mode", 32'h0000_00AA, rd);
    apb(1'b1, `REG_CMD_OFF, 32'h0000_0002);
    apb(1'b0, `REG_CMD_OFF, 32'h0000_0000);
    cmp("armed", 0, rd);
    fire(0);
    settle();
    judge();
    apb(1'b1, `REG_MODE_OFF, 32'h0000_0000);
    apb(1'b1, `REG_CTRL_OFF, 32'h0000_0001);
    plan(8'h00);
    fire(1);
    settle();
    judge();
    fire(2);
    settle();
    judge();
    apb(1'b1, `REG_CTRL_OFF, 32'h0000_0009);
    plan(8'h00);
    fire(2);
    settle();
    judge();
    apb(1'b1, `REG_CTRL_OFF, 32'h0000_0005);
    plan(8'h00);
    repeat (exq.size())
    begin
      fire(1);
      settle();
    end
    judge();
    apb(1'b1, `REG_CTRL_OFF, 32'h0000_0006);
    plan(8'h00);
    fire(0);
    apb(1'b0, `REG_STATUS_OFF, 32'h0000_0000);
    cmp("status", 32'h0000_0001, rd);
    cmp("busy", 1, busy);
    settle();
    judge();
    apb(1'b1, 12'h024, xs());
    cmp("write err", 1, err);
    apb(1'b0, 12'h020, 32'h0000_0000);
    cmp("read err", 1, err);
    cmp("read data", 0, rd);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
